// [shared/fic_pkg.sv]
// constants, enumerations and carriers for the flash iap command interface
// assumes an 8-bit special function register bus and a self-timed flash macro
package fic_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_CONFIG    = 8'hb1;
   localparam logic [7:0] ADDR_COMMAND   = 8'hb2;
   localparam logic [7:0] ADDR_ADDR_LOW  = 8'hb3;
   localparam logic [7:0] ADDR_ADDR_HIGH = 8'hb4;
   localparam logic [7:0] ADDR_DATA      = 8'hb5;
   localparam logic [7:0] ADDR_STATUS    = 8'hb6;

   // ==========================================================
   // field positions and reset values
   localparam int CFG_VIS_BIT       = 7;
   localparam int CFG_IAP_ENABLE_BIT = 6;
   localparam int CMD_IRQ_ENABLE_BIT = 7;
   localparam int ST_SEC_HI_BIT     = 7;
   localparam int ST_SEC_LO_BIT     = 5;
   localparam int ST_BUSY_BIT       = 3;
   localparam int ST_FLASH_BUSY_BIT = 2;
   localparam logic [7:0] COMMAND_RST = 8'h00;
   localparam logic [7:0] ADDR_RST    = 8'h00;
   localparam logic [7:0] DATA_RST    = 8'h00;
   localparam logic [1:0] CFG_TOP_RST = 2'h0;
   localparam logic [1:0] MAP_EN_RST  = 2'h0;

   // ==========================================================
   // command codes
   localparam logic [6:0] CODE_CHIP_ERASE   = 7'h01;
   localparam logic [6:0] CODE_BURST_PROG   = 7'h06;
   localparam logic [6:0] CODE_SECTOR_ERASE = 7'h0b;
   localparam logic [6:0] CODE_BYTE_VERIFY  = 7'h0c;
   localparam logic [6:0] CODE_BLOCK_ERASE  = 7'h0d;
   localparam logic [6:0] CODE_BYTE_PROG    = 7'h0e;
   localparam logic [6:0] CODE_PROG_SEC1    = 7'h0f;
   localparam logic [6:0] CODE_PROG_SEC2    = 7'h03;
   localparam logic [6:0] CODE_PROG_SEC3    = 7'h05;
   localparam logic [6:0] CODE_PROG_REMAP0  = 7'h08;
   localparam logic [6:0] CODE_PROG_REMAP1  = 7'h09;

   // ==========================================================
   // remap windows
   localparam logic [15:0] REMAP_BASE    = 16'hf000;
   localparam logic [15:0] REMAP_MASK_1K = 16'h03ff;
   localparam logic [15:0] REMAP_MASK_2K = 16'h07ff;
   localparam logic [15:0] REMAP_MASK_4K = 16'h0fff;

   // ==========================================================
   // timing: a verify read takes one machine cycle (twelve core clocks)
   localparam int CLK_PERIOD_NS     = 10;
   localparam int VERIFY_TIME_NS    = 120;
   localparam int VERIFY_CLKS       = (VERIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] VERIFY_CNT_INIT = 4'(VERIFY_CLKS - 1);
   localparam logic [3:0] CNT_ZERO  = 4'h0;
   localparam logic [3:0] CNT_ONE   = 4'h1;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      OP_NONE, OP_CHIP_ERASE, OP_BURST_PROG, OP_SECTOR_ERASE, OP_BYTE_VERIFY, OP_BLOCK_ERASE,
      OP_BYTE_PROG, OP_PROG_SEC1, OP_PROG_SEC2, OP_PROG_SEC3, OP_PROG_REMAP0, OP_PROG_REMAP1
   } fic_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_VERIFY = 3'b010,
      ST_RUN    = 3'b100
   } fic_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fic_sfr_req_t;

   typedef struct packed {
      logic        start;
      logic        next_byte;
      fic_op_t     op;
      logic [15:0] addr;
      logic [7:0]  data;
   } fic_flash_req_t;

   typedef struct packed {
      logic       byte_done;
      logic       op_done;
      logic [7:0] rdata;
   } fic_flash_rsp_t;

endpackage

// [src/fic_cmd_decode.sv]
// command code decoder for the flash iap command interface
// assumes the code is the low seven bits of a written command byte
module fic_cmd_decode (
   input  wire logic [6:0]      code,
   output fic_pkg::fic_op_t     op,
   output logic                 valid,
   output logic                 is_verify
);
   import fic_pkg::*;

   // ==========================================================
   // decode; anything unlisted is reserved and starts nothing
   always_comb begin
      op = OP_NONE;
      case (code)
         CODE_CHIP_ERASE:   op = OP_CHIP_ERASE;
         CODE_BURST_PROG:   op = OP_BURST_PROG;
         CODE_SECTOR_ERASE: op = OP_SECTOR_ERASE;
         CODE_BYTE_VERIFY:  op = OP_BYTE_VERIFY;
         CODE_BLOCK_ERASE:  op = OP_BLOCK_ERASE;
         CODE_BYTE_PROG:    op = OP_BYTE_PROG;
         CODE_PROG_SEC1:    op = OP_PROG_SEC1;
         CODE_PROG_SEC2:    op = OP_PROG_SEC2;
         CODE_PROG_SEC3:    op = OP_PROG_SEC3;
         CODE_PROG_REMAP0:  op = OP_PROG_REMAP0;
         CODE_PROG_REMAP1:  op = OP_PROG_REMAP1;
         default:           op = OP_NONE;
      endcase
   end

   assign valid     = (op != OP_NONE);
   assign is_verify = (op == OP_BYTE_VERIFY);

endmodule

// [src/fic_remap.sv]
// program fetch address remapper
// assumes the map enable field comes straight from the configuration register
module fic_remap (
   input  wire logic [1:0]  map_en,
   input  wire logic [15:0] fetch_addr,
   output logic [15:0]      mapped_addr
);
   import fic_pkg::*;

   logic [15:0] mask;

   // ==========================================================
   // window size by map enable; 00 leaves memory in normal order
   always_comb begin
      mask = REMAP_MASK_4K;
      case (map_en)
         2'h1:    mask = REMAP_MASK_1K;
         2'h2:    mask = REMAP_MASK_2K;
         default: mask = REMAP_MASK_4K;
      endcase
   end

   // fetches inside the low window are pushed up to the top block
   always_comb begin
      mapped_addr = fetch_addr;
      if (map_en != 2'h0 && (fetch_addr & ~mask) == 16'h0000) begin
         mapped_addr = REMAP_BASE | (fetch_addr & mask);
      end
   end

endmodule

// [src/fic_top.sv]
// flash iap command interface: sfr mailbox, command sequencer, remap and irq1 takeover
// assumes a self-timed flash macro answering with op_done and, in burst mode, byte_done
// assumes sfr bus requests are single-cycle strobes synchronous to core_clk

// Function
// - on the first enabled edge after reset the remap enable field loads from the inverted nonvolatile remap setting.
// - remap enable 01/10/11 redirects low 1/2/4 KByte fetches to F000H upward.
// - interrupt enable high makes the irq1 line signal completion and ignores external requests.
// - command byte holds interrupt enable and seven-bit code; resets to zero.
// - code 0Bh is sector erase, 0Ch is byte verify read.
// - code 0Dh is block erase, 0Eh is byte program.
// - 0Fh/03h/05h program security bits one to three; 08h/09h program remap bits.
// - unlisted codes are reserved and start no flash operation.
// - verify finishes in one machine cycle and never raises the completion interrupt.
// - low address mailbox, eight bits, resets to zero.
// - high address mailbox, eight bits, resets to zero.
// - data mailbox carries program data in and verify data out, resets to zero.
// - status is read-only; bits 7..5 show security bits one to three.
// - status bit 3 is high while busy, low once the next burst byte fits.
// - status bit 2 stays high until the last command, burst included, fully ends.
module fic_top (
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   input  wire fic_pkg::fic_sfr_req_t   sfr_req,
   output logic [7:0]                   sfr_rdata,
   input  wire logic [1:0]              nonvolatile_remap_setting,
   input  wire logic [2:0]              security_bits,
   output fic_pkg::fic_flash_req_t      flash_req,
   input  wire fic_pkg::fic_flash_rsp_t flash_rsp,
   input  wire logic                    ext_irq1_n,
   output logic                         cpu_irq1_n,
   output logic                         block1_visible,
   input  wire logic [15:0]             fetch_addr,
   output logic [15:0]                  fetch_addr_mapped
);
   import fic_pkg::*;

   // ==========================================================
   // state
   logic [1:0]  cfg_top_ff,  nxt_cfg_top;     // {vis, iap_enable}
   logic [1:0]  map_en_ff,   nxt_map_en;      // {remap_enable_hi, remap_enable_lo}
   logic        strap_ff,    nxt_strap;
   logic [7:0]  command_ff,  nxt_command;
   logic [7:0]  addr_lo_ff,  nxt_addr_lo;
   logic [7:0]  addr_hi_ff,  nxt_addr_hi;
   logic [7:0]  data_ff,     nxt_data;
   logic [7:0]  rdata_ff,    nxt_rdata;
   fic_state_t  state_ff,    nxt_state;
   fic_op_t     op_ff,       nxt_op;
   logic        busy_ff,     nxt_busy;
   logic        fbusy_ff,    nxt_fbusy;
   logic [3:0]  cnt_ff,      nxt_cnt;
   logic        start_ff,    nxt_start;
   logic        next_ff,     nxt_next;
   logic        irq1_n_ff,   nxt_irq1_n;
   logic [15:0] mapped_ff;

   fic_op_t     dec_op;
   logic        dec_valid;
   logic        dec_verify;
   logic [15:0] mapped_comb;
   logic        wr_cmd;
   logic        wr_data;
   logic        cmd_go;
   logic        burst_go;
   logic        load_verify;
   logic        done_irq;
   logic        iap_enable;
   logic        flash_irq_enable;

   assign iap_enable       = cfg_top_ff[0];
   assign flash_irq_enable = command_ff[CMD_IRQ_ENABLE_BIT];
   assign wr_cmd           = sfr_req.wr && sfr_req.addr == ADDR_COMMAND;
   assign wr_data          = sfr_req.wr && sfr_req.addr == ADDR_DATA;

   fic_cmd_decode u_decode (
      .code      (sfr_req.wdata[6:0]),
      .op        (dec_op),
      .valid     (dec_valid),
      .is_verify (dec_verify)
   );

   fic_remap u_remap (
      .map_en      (map_en_ff),
      .fetch_addr  (fetch_addr),
      .mapped_addr (mapped_comb)
   );

   // a command is taken only when enabled, listed and the sequencer is free
   assign cmd_go   = wr_cmd && iap_enable && dec_valid && state_ff == ST_IDLE;
   // a data write during burst program feeds the next byte once the last one is in
   assign burst_go = wr_data && state_ff == ST_RUN && op_ff == OP_BURST_PROG && !busy_ff;

   // ==========================================================
   // command sequencer
   always_comb begin
      nxt_state   = state_ff;
      nxt_op      = op_ff;
      nxt_busy    = busy_ff;
      nxt_fbusy   = fbusy_ff;
      nxt_cnt     = cnt_ff;
      nxt_start   = 1'b0;
      nxt_next    = 1'b0;
      load_verify = 1'b0;
      done_irq    = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (cmd_go) begin
               nxt_op    = dec_op;
               nxt_start = 1'b1;
               nxt_busy  = 1'b1;
               nxt_fbusy = 1'b1;
               nxt_cnt   = VERIFY_CNT_INIT;
               nxt_state = dec_verify ? ST_VERIFY : ST_RUN;
            end
         end
         ST_VERIFY: begin
            // fixed latency; the macro's done strobe is not needed here
            if (cnt_ff == CNT_ZERO) begin
               load_verify = 1'b1;
               nxt_busy    = 1'b0;
               nxt_fbusy   = 1'b0;
               nxt_state   = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end
         end
         ST_RUN: begin
            if (flash_rsp.op_done) begin
               nxt_busy  = 1'b0;
               nxt_fbusy = 1'b0;
               done_irq  = flash_irq_enable;
               nxt_state = ST_IDLE;
            end else begin
               if (flash_rsp.byte_done) begin
                  nxt_busy = 1'b0;
               end
               if (burst_go) begin
                  nxt_busy = 1'b1;
                  nxt_next = 1'b1;
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_busy  = 1'b0;
            nxt_fbusy = 1'b0;
         end
      endcase
   end

   // irq1 is either the pin passed through or a one-cycle completion pulse
   always_comb begin
      nxt_irq1_n = ext_irq1_n;
      if (flash_irq_enable) begin
         nxt_irq1_n = !done_irq;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff  <= ST_IDLE;
         op_ff     <= OP_NONE;
         busy_ff   <= 1'b0;
         fbusy_ff  <= 1'b0;
         cnt_ff    <= CNT_ZERO;
         start_ff  <= 1'b0;
         next_ff   <= 1'b0;
         irq1_n_ff <= 1'b1;
         mapped_ff <= 16'h0000;
      end else if (ce) begin
         state_ff  <= nxt_state;
         op_ff     <= nxt_op;
         busy_ff   <= nxt_busy;
         fbusy_ff  <= nxt_fbusy;
         cnt_ff    <= nxt_cnt;
         start_ff  <= nxt_start;
         next_ff   <= nxt_next;
         irq1_n_ff <= nxt_irq1_n;
         mapped_ff <= mapped_comb;
      end
   end

   // ==========================================================
   // sfr mailbox registers
   always_comb begin
      nxt_cfg_top = cfg_top_ff;
      nxt_map_en  = map_en_ff;
      nxt_strap   = 1'b1;
      nxt_command = command_ff;
      nxt_addr_lo = addr_lo_ff;
      nxt_addr_hi = addr_hi_ff;
      nxt_data    = data_ff;
      nxt_rdata   = rdata_ff;
      // the strap is sampled on the first enabled edge after reset; code 11 means off
      if (!strap_ff) begin
         nxt_map_en = ~nonvolatile_remap_setting;
      end else if (sfr_req.wr && sfr_req.addr == ADDR_CONFIG) begin
         nxt_map_en = sfr_req.wdata[1:0];
      end
      if (sfr_req.wr && sfr_req.addr == ADDR_CONFIG) begin
         nxt_cfg_top = sfr_req.wdata[CFG_VIS_BIT:CFG_IAP_ENABLE_BIT];
      end else if (wr_cmd) begin
         // the interrupt enable always follows; the code only when iap is on
         nxt_command[CMD_IRQ_ENABLE_BIT] = sfr_req.wdata[CMD_IRQ_ENABLE_BIT];
         if (iap_enable) begin
            nxt_command[6:0] = sfr_req.wdata[6:0];
         end
      end else if (sfr_req.wr && sfr_req.addr == ADDR_ADDR_LOW) begin
         nxt_addr_lo = sfr_req.wdata;
      end else if (sfr_req.wr && sfr_req.addr == ADDR_ADDR_HIGH) begin
         nxt_addr_hi = sfr_req.wdata;
      end else if (wr_data) begin
         nxt_data = sfr_req.wdata;
      end
      // verify data from the array wins over a cpu write in the same cycle
      if (load_verify) begin
         nxt_data = flash_rsp.rdata;
      end
      // read path; status has no write decode at all
      if (sfr_req.rd) begin
         if (sfr_req.addr == ADDR_CONFIG) begin
            nxt_rdata = {cfg_top_ff, 4'h0, map_en_ff};
         end else if (sfr_req.addr == ADDR_COMMAND) begin
            nxt_rdata = command_ff;
         end else if (sfr_req.addr == ADDR_ADDR_LOW) begin
            nxt_rdata = addr_lo_ff;
         end else if (sfr_req.addr == ADDR_ADDR_HIGH) begin
            nxt_rdata = addr_hi_ff;
         end else if (sfr_req.addr == ADDR_DATA) begin
            nxt_rdata = data_ff;
         end else if (sfr_req.addr == ADDR_STATUS) begin
            nxt_rdata = 8'h00;
            nxt_rdata[ST_SEC_HI_BIT:ST_SEC_LO_BIT] = security_bits;
            nxt_rdata[ST_BUSY_BIT]       = busy_ff;
            nxt_rdata[ST_FLASH_BUSY_BIT] = fbusy_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_top_ff <= CFG_TOP_RST;
         map_en_ff  <= MAP_EN_RST;
         strap_ff   <= 1'b0;
         command_ff <= COMMAND_RST;
         addr_lo_ff <= ADDR_RST;
         addr_hi_ff <= ADDR_RST;
         data_ff    <= DATA_RST;
         rdata_ff   <= 8'h00;
      end else if (ce) begin
         cfg_top_ff <= nxt_cfg_top;
         map_en_ff  <= nxt_map_en;
         strap_ff   <= nxt_strap;
         command_ff <= nxt_command;
         addr_lo_ff <= nxt_addr_lo;
         addr_hi_ff <= nxt_addr_hi;
         data_ff    <= nxt_data;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ==========================================================
   // outputs; the macro samples the mailboxes as they stand after the start
   assign sfr_rdata           = rdata_ff;
   assign flash_req.start     = start_ff;
   assign flash_req.next_byte = next_ff;
   assign flash_req.op        = op_ff;
   assign flash_req.addr      = {addr_hi_ff, addr_lo_ff};
   assign flash_req.data      = data_ff;
   assign cpu_irq1_n          = irq1_n_ff;
   assign block1_visible      = cfg_top_ff[1];
   assign fetch_addr_mapped   = mapped_ff;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_strap_load: assert property (ce && !strap_ff |=> map_en_ff == ~$past(nonvolatile_remap_setting))
      else $error("remap field not loaded from strap");
   a_remap_1k: assert property (ce && map_en_ff == 2'h1 && fetch_addr < 16'h0400 |=>
      fetch_addr_mapped == (16'hf000 | $past(fetch_addr)))
      else $error("1k remap window wrong");
   a_ext_ignored: assert property (ce && flash_irq_enable && !(state_ff == ST_RUN && flash_rsp.op_done)
      |=> cpu_irq1_n)
      else $error("external irq1 request leaked while taken over");
   a_ext_pass: assert property (ce && !flash_irq_enable |=> cpu_irq1_n == $past(ext_irq1_n))
      else $error("irq1 not passed through");
   a_done_irq: assert property (ce && flash_irq_enable && state_ff == ST_RUN && flash_rsp.op_done
      |=> !cpu_irq1_n && !fbusy_ff)
      else $error("completion pulse missing");
   a_reserved_noop: assert property (ce && state_ff == ST_IDLE && wr_cmd && !dec_valid
      |=> state_ff == ST_IDLE && !flash_req.start)
      else $error("reserved code started an operation");
   a_verify_time: assert property (disable iff (rst || !ce) ce && cmd_go && dec_verify
      |-> ##12 fbusy_ff ##1 !fbusy_ff)
      else $error("verify latency wrong");
   a_verify_noirq: assert property (ce && flash_irq_enable && state_ff == ST_VERIFY |=> cpu_irq1_n)
      else $error("verify raised the completion interrupt");
   a_status_sec: assert property (ce && sfr_req.rd && sfr_req.addr == ADDR_STATUS
      |=> sfr_rdata[7:5] == $past(security_bits) && sfr_rdata[3] == $past(busy_ff))
      else $error("status readback wrong");
   a_burst_ready: assert property (ce && state_ff == ST_RUN && flash_rsp.byte_done && !flash_rsp.op_done
      |=> !busy_ff && fbusy_ff)
      else $error("burst ready not shown");
   a_fbusy_hold: assert property (ce && state_ff == ST_RUN && !flash_rsp.op_done |=> fbusy_ff)
      else $error("flash busy dropped early");
   a_iap_gate: assert property (ce && state_ff == ST_IDLE && wr_cmd && !iap_enable
      |=> state_ff == ST_IDLE && !fbusy_ff)
      else $error("command taken with iap off");
   a_cmd_start: assert property (ce && cmd_go |=> flash_req.start && busy_ff && fbusy_ff
      && flash_req.op == $past(dec_op))
      else $error("command did not start");

   c_verify: cover property (ce && cmd_go && dec_verify);
   c_burst_next: cover property (ce && burst_go);
   c_erase_irq: cover property (ce && done_irq);

endmodule

// [bench/tb.sv]
// self-checking bench for the flash iap command interface
// assumes fic_pkg is compiled first; the bench itself plays the flash macro and the cpu
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fic_pkg::*;

   // ==========================================================
   // signals
   logic           core_clk  = 1'b0;
   logic           rst       = 1'b1;
   fic_sfr_req_t   sfr_req   = '0;
   logic [7:0]     sfr_rdata;
   logic [1:0]     strap     = 2'h2;
   logic [2:0]     sec       = 3'h5;
   fic_flash_req_t flash_req;
   fic_flash_rsp_t flash_rsp = '{byte_done: 1'b0, op_done: 1'b0, rdata: 8'ha5};
   logic           ext_n     = 1'b1;
   logic           irq1_n;
   logic           vis;
   logic [15:0]    fetch     = 16'h0123;
   logic [15:0]    fetch_m;
   logic [7:0]     rd_val;
   int             n_errors  = 0;
   int             tests_run = 0;
   // one row per listed command: code beside the operation it must start
   logic [6:0]     codes [11] = '{CODE_CHIP_ERASE, CODE_BURST_PROG, CODE_SECTOR_ERASE, CODE_BYTE_VERIFY,
      CODE_BLOCK_ERASE, CODE_BYTE_PROG, CODE_PROG_SEC1, CODE_PROG_SEC2, CODE_PROG_SEC3,
      CODE_PROG_REMAP0, CODE_PROG_REMAP1};
   fic_op_t        ops [11] = '{OP_CHIP_ERASE, OP_BURST_PROG, OP_SECTOR_ERASE, OP_BYTE_VERIFY,
      OP_BLOCK_ERASE, OP_BYTE_PROG, OP_PROG_SEC1, OP_PROG_SEC2, OP_PROG_SEC3, OP_PROG_REMAP0, OP_PROG_REMAP1};

   // ==========================================================
   // clock and design; ce is tied high since freezing is not under test
   always #5 core_clk = ~core_clk;

   fic_top dut (
      .core_clk                  (core_clk),
      .rst                       (rst),
      .ce                        (1'b1),
      .sfr_req                   (sfr_req),
      .sfr_rdata                 (sfr_rdata),
      .nonvolatile_remap_setting (strap),
      .security_bits             (sec),
      .flash_req                 (flash_req),
      .flash_rsp                 (flash_rsp),
      .ext_irq1_n                (ext_n),
      .cpu_irq1_n                (irq1_n),
      .block1_visible            (vis),
      .fetch_addr                (fetch),
      .fetch_addr_mapped         (fetch_m)
   );

   // ==========================================================
   // helpers; every input moves on the falling edge so the rising edge sees it settled
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge core_clk);
      sfr_req.wr = 1'b0;
   endtask

   // read data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(negedge core_clk);
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge core_clk);
      sfr_req.rd = 1'b0;
      rd_val = sfr_rdata;
   endtask

   task automatic pulse_done();
      @(negedge core_clk);
      flash_rsp.op_done = 1'b1;
      @(negedge core_clk);
      flash_rsp.op_done = 1'b0;
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      n_errors++;
      test_done();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      for (int a = 2; a <= 5; a++) begin
         rd(8'hb0 + 8'(a));
         chk(rd_val, 8'h00);
      end
      rd(ADDR_CONFIG);
      chk(rd_val, 8'h01);
      chk(vis, 1'b0);
      chk(fetch_m, 16'hf123);
      chk(irq1_n, 1'b1);
      // iap still off: a command code must start nothing
      wr(ADDR_COMMAND, 8'h01);
      chk(flash_req.start, 1'b0);
      // remap windows of 2 and 4 KByte width, then none
      fetch = 16'h0400;
      wr(ADDR_CONFIG, 8'h42);
      @(negedge core_clk);
      chk(fetch_m, 16'hf400);
      fetch = 16'h0abc;
      wr(ADDR_CONFIG, 8'h43);
      @(negedge core_clk);
      chk(fetch_m, 16'hfabc);
      wr(ADDR_CONFIG, 8'hc0);
      @(negedge core_clk);
      chk(fetch_m, 16'h0abc);
      chk(vis, 1'b1);
      rd(ADDR_CONFIG);
      chk(rd_val, 8'hc0);
      wr(ADDR_ADDR_LOW, 8'h34);
      wr(ADDR_ADDR_HIGH, 8'h12);
      wr(ADDR_DATA, 8'h56);
      chk(flash_req.addr, 16'h1234);
      chk(flash_req.data, 8'h56);
      // every listed command with completion interrupt on; the bench plays code in the primary block
      for (int i = 0; i < 11; i++) begin
         wr(ADDR_COMMAND, {1'b1, codes[i]});
         chk(flash_req.start, 1'b1);
         chk(flash_req.op, ops[i]);
         if (ops[i] == OP_BYTE_VERIFY) begin
            repeat (12) begin
               @(negedge core_clk);
               chk(irq1_n, 1'b1);
            end
            rd(ADDR_DATA);
            chk(rd_val, 8'ha5);
         end else begin
            rd(ADDR_STATUS);
            chk(rd_val, 8'hac);
            pulse_done();
            chk(irq1_n, 1'b0);
         end
         rd(ADDR_STATUS);
         chk(rd_val, 8'ha0);
      end
      // reserved code and a write to the read-only status
      wr(ADDR_COMMAND, 8'h02);
      chk(flash_req.start, 1'b0);
      wr(ADDR_STATUS, 8'hff);
      rd(ADDR_STATUS);
      chk(rd_val, 8'ha0);
      // burst: data while busy is refused, then accepted once the byte is taken
      wr(ADDR_COMMAND, 8'h06);
      wr(ADDR_DATA, 8'h11);
      chk(flash_req.next_byte, 1'b0);
      @(negedge core_clk);
      flash_rsp.byte_done = 1'b1;
      @(negedge core_clk);
      flash_rsp.byte_done = 1'b0;
      rd(ADDR_STATUS);
      chk(rd_val, 8'ha4);
      wr(ADDR_DATA, 8'h77);
      chk(flash_req.next_byte, 1'b1);
      chk(flash_req.data, 8'h77);
      rd(ADDR_STATUS);
      chk(rd_val, 8'hac);
      pulse_done();
      chk(irq1_n, 1'b1);
      rd(ADDR_STATUS);
      chk(rd_val, 8'ha0);
      // external request passes with interrupt enable off, is hidden with it on
      ext_n = 1'b0;
      @(negedge core_clk);
      chk(irq1_n, 1'b0);
      wr(ADDR_COMMAND, 8'h80);
      @(negedge core_clk);
      chk(irq1_n, 1'b1);
      // a second reset mid-run, with remapping strapped off this time
      strap = 2'h3;
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      chk(vis, 1'b0);
      rd(ADDR_CONFIG);
      chk(rd_val, 8'h00);
      rd(ADDR_COMMAND);
      chk(rd_val, 8'h00);
      test_done();
   end
endmodule
